// ===== bcot_defs.svh
/*
 * constants for the baud and clock-out timer: speed scaling, reset
 * filter lengths and reload arithmetic.
 * assumes inclusion by bare name from the package and the modules.
 */
`ifndef BCOT_DEFS_SVH
`define BCOT_DEFS_SVH

// ************************************************************
// speed and reset timing
// ************************************************************
`define BCOT_RST_OSC_12CLK   24   // oscillator periods, 12-clock mode
`define BCOT_RST_OSC_6CLK    12   // oscillator periods, 6-clock mode
`define BCOT_CNT_W           16   // count and reload width
`define BCOT_BAUD_DIV        16   // overflows per serial bit
`define BCOT_BAUD_DIV_W      4

`endif

// ===== bcot_pkg.sv
/*
 * types for the baud and clock-out timer.
 * assumes bcot_defs.svh is on the include path.
 */
`include "bcot_defs.svh"

package bcot_pkg;

   // ************************************************************
   // speed of the core clocking
   // ************************************************************
   typedef enum logic
   {
      BCOT_SPEED_12 = 1'b0,
      BCOT_SPEED_6  = 1'b1
   } bcot_speed_t;

   // ************************************************************
   // reset filter states, gray coded along the path
   // ************************************************************
   typedef enum logic [1:0]
   {
      BCOT_RS_IDLE  = 2'b00,
      BCOT_RS_COUNT = 2'b01,
      BCOT_RS_HELD  = 2'b11
   } bcot_rstate_t;

endpackage

// ===== bcot_reset_filter.sv
/*
 * reset pin filter: asserts a reset request once the synchronised reset
 * pin has stayed high for two machine cycles of oscillator periods.
 * assumes clk is the oscillator and the pin is already synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bcot_defs.svh"

module bcot_reset_filter
   import bcot_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // control
   input  wire logic pinHigh,
   input  wire logic sixClock,
   // result
   output logic      resetReq
);

   logic [4:0]   cnt_r;
   bcot_rstate_t state_r;
   logic [4:0]   need;

   // length depends on current speed
   assign need = sixClock ? 5'(`BCOT_RST_OSC_6CLK - 1)
                          : 5'(`BCOT_RST_OSC_12CLK - 1);

   // count consecutive high cycles
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r  <= BCOT_RS_IDLE;
         cnt_r    <= 5'h00;
         resetReq <= 1'b0;
      end
      else if (!pinHigh)
      begin
         state_r  <= BCOT_RS_IDLE;
         cnt_r    <= 5'h00;
         resetReq <= 1'b0;
      end
      else
      begin
         case (state_r)
            BCOT_RS_IDLE:
            begin
               state_r <= BCOT_RS_COUNT;
               cnt_r   <= 5'h01; // first high cycle counts as one
            end
            BCOT_RS_COUNT:
            begin
               if (cnt_r >= need) // [RQ5]
               begin
                  state_r  <= BCOT_RS_HELD;
                  resetReq <= 1'b1;
               end
               else
                  cnt_r <= cnt_r + 5'h01;
            end
            BCOT_RS_HELD:
               resetReq <= 1'b1;
            default:
               state_r <= BCOT_RS_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

// ===== bcot_timer.sv
/*
 * baud and clock-out timer: 16-bit reload counter feeding serial bit
 * ticks and a 50% clock-out pin, plus speed select and reset filter.
 * assumes clk is the oscillator; pins arrive asynchronous; control
 * bits come from same-clock register logic as plain ports.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bcot_defs.svh"

// What this block does
// RQ1 - speed bit 0 gives 12-clock mode, 1 gives 6-clock mode
// RQ2 - programmed speed fuse forces 6-clock mode regardless of speed bit
// RQ3 - speed bit writable any time; 6-clock halves all timing intervals
// RQ4 - after reset run 12-clock unless the fuse selects 6-clock
// RQ5 - reset taken after pin high 24 periods (12-clk) or 12 (6-clk)
// RQ6 - clock-out active only with counter select 0, enable and run set
// RQ7 - clock-out frequency is osc over n times (65536 minus reload)
// RQ8 - rollovers in clock-out mode raise no interrupt
// RQ9 - baud and clock-out may run together from one reload and rate
// RQ10 - transmit and receive clock selects route each baud source
// RQ11 - in baud mode a high byte rollover reloads both count bytes
// RQ12 - serial bit rate equals overflow rate divided by 16
// RQ13 - baud timer counts at osc (6-clk) or half osc (12-clk)
// RQ14 - internal bit rate is osc over 16 or 32 times reload span
// RQ15 - baud behaviour only while a transmit or receive select is 1
// RQ16 - baud mode rollover sets no overflow flag and no interrupt
// RQ17 - baud mode trigger falling edge sets external flag, no reload
// RQ18 - software stops the timer before touching count or reload
// RQ19 - clock-out pin toggles on every overflow
module bcot_timer
   import bcot_pkg::*;
#(
   parameter int CNT_W = `BCOT_CNT_W
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // speed control
   input  wire logic             double_speed_select,
   input  wire logic             fused_double_speed,
   // timer control
   input  wire logic             timer_two_run,
   input  wire logic             timer_or_counter_select,
   input  wire logic             clockout_enable,
   input  wire logic             transmit_clock_source,
   input  wire logic             receive_clock_source,
   input  wire logic             external_trigger_enable,
   input  wire logic             extFlagClear,
   input  wire logic [CNT_W-1:0] reloadValue,
   // pins
   input  wire logic             resetPin,
   input  wire logic             countPinIn,
   input  wire logic             trigger_input_pin,
   output logic                  countPinOut,
   output logic                  countPinOe,
   // serial port ticks
   output logic                  txBaudTick,
   output logic                  rxBaudTick,
   output logic                  txUseThisTimer,
   output logic                  rxUseThisTimer,
   // status
   output logic                  sixClockMode,
   output logic                  resetRequest,
   output logic                  external_trigger_flag,
   output logic                  overflow_flag,
   output logic                  timerIrq,
   output logic [CNT_W-1:0]      countValue
);

   // ************************************************************
   // signals
   // ************************************************************
   logic [2:0]       resSync_r;
   logic [2:0]       cntSync_r;
   logic [2:0]       trgSync_r;
   logic             sixClock;
   logic             baudMode;
   logic             clkOutMode;
   logic             countEn;
   logic [CNT_W-1:0] count_r;
   logic             overflow;
   logic             prescale_r;
   logic [`BCOT_BAUD_DIV_W-1:0] baudDiv_r;
   logic             resetFiltered;

   // ************************************************************
   // input synchronisers
   // ************************************************************
   // two flops, third stage for edge detection
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         resSync_r <= 3'h0;
         cntSync_r <= 3'h0;
         trgSync_r <= 3'h7;
      end
      else
      begin
         resSync_r <= {resSync_r[1:0], resetPin};
         cntSync_r <= {cntSync_r[1:0], countPinIn};
         trgSync_r <= {trgSync_r[1:0], trigger_input_pin};
      end
   end

   // ************************************************************
   // speed selection
   // ************************************************************
   // fuse supersedes software bit; bit low after reset
   assign sixClock = fused_double_speed      // [RQ2] [RQ4]
                   | double_speed_select;    // [RQ1] [RQ3]

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         sixClockMode <= 1'b0;
      else
         sixClockMode <= sixClock;
   end

   // ************************************************************
   // reset pin filter
   // ************************************************************
   bcot_reset_filter u_resetFilter
   (
      .clk      (clk),
      .reset_n  (reset_n),
      .pinHigh  (resSync_r[1]),
      .sixClock (sixClock),
      .resetReq (resetFiltered)
   );

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         resetRequest <= 1'b0;
      else
         resetRequest <= resetFiltered; // [RQ5]
   end

   // ************************************************************
   // mode decode
   // ************************************************************
   assign baudMode   = transmit_clock_source
                     | receive_clock_source;                // [RQ15]
   assign clkOutMode = !timer_or_counter_select
                     & clockout_enable & timer_two_run;     // [RQ6]

   // ************************************************************
   // count prescaler
   // ************************************************************
   // half rate in 12-clock, full rate in 6-clock
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         prescale_r <= 1'b0;
      else
         prescale_r <= !prescale_r;
   end

   // enable: external falling edge in counter mode, else prescaled osc
   always_comb
   begin
      if (!timer_two_run)
         countEn = 1'b0;
      else if (timer_or_counter_select)
         countEn = cntSync_r[2] & !cntSync_r[1];
      else
         countEn = sixClock | prescale_r;                    // [RQ13] [RQ3]
   end

   assign overflow = countEn & (&count_r);

   // ************************************************************
   // counter with reload
   // ************************************************************
   // any high byte rollover reloads the whole pair
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         count_r <= '0;
      else if (overflow)
         count_r <= reloadValue;                             // [RQ11] [RQ9]
      else if (countEn)
         count_r <= count_r + CNT_W'(1);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         countValue <= '0;
      else
         countValue <= count_r; // valid only when stopped [RQ18]
   end

   // ************************************************************
   // overflow flag and interrupt
   // ************************************************************
   // no flag in baud or clock-out mode; only reset clears it
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         overflow_flag <= 1'b0;
      else if (overflow && !baudMode && !clkOutMode)         // [RQ16] [RQ8]
         overflow_flag <= 1'b1;
   end

   // ************************************************************
   // external trigger flag
   // ************************************************************
   // falling edge sets flag; reload untouched in baud mode
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         external_trigger_flag <= 1'b0;
      else if (external_trigger_enable
               && trgSync_r[2] && !trgSync_r[1])              // [RQ17]
         external_trigger_flag <= 1'b1;
      else if (extFlagClear)
         external_trigger_flag <= 1'b0;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         timerIrq <= 1'b0;
      else
         timerIrq <= overflow_flag | external_trigger_flag;
   end

   // ************************************************************
   // clock-out pin
   // ************************************************************
   // toggle per overflow gives n = 2 or 4 overall
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         countPinOut <= 1'b0;
         countPinOe  <= 1'b0;
      end
      else
      begin
         countPinOe <= clkOutMode;                            // [RQ6]
         if (!clkOutMode)
            countPinOut <= 1'b0;
         else if (overflow)
            countPinOut <= !countPinOut;                      // [RQ19] [RQ7]
      end
   end

   // ************************************************************
   // baud ticks
   // ************************************************************
   // one tick per 16 overflows: osc over 16 or 32 times span
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         baudDiv_r <= '0;
      else if (!baudMode)
         baudDiv_r <= '0;
      else if (overflow)
         baudDiv_r <= baudDiv_r
                      + {{(`BCOT_BAUD_DIV_W-1){1'b0}}, 1'b1}; // [RQ12]
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         txBaudTick     <= 1'b0;
         rxBaudTick     <= 1'b0;
         txUseThisTimer <= 1'b0;
         rxUseThisTimer <= 1'b0;
      end
      else
      begin
         txUseThisTimer <= transmit_clock_source;             // [RQ10]
         rxUseThisTimer <= receive_clock_source;
         txBaudTick <= transmit_clock_source && overflow
                       && (&baudDiv_r);                       // [RQ14]
         rxBaudTick <= receive_clock_source && overflow
                       && (&baudDiv_r);
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_speed;
      @(posedge clk) disable iff (!reset_n)
      fused_double_speed |=> sixClockMode;
   endproperty
   a_speed: assert property (p_speed) // [RQ2]
      else $error("fuse did not force six clock mode");

   property p_oe;
      @(posedge clk) disable iff (!reset_n)
      (clockout_enable && timer_two_run && !timer_or_counter_select)
      |=> countPinOe;
   endproperty
   a_oe: assert property (p_oe) // [RQ6]
      else $error("clock out not enabled");

   property p_noflag;
      @(posedge clk) disable iff (!reset_n)
      (overflow && baudMode && !overflow_flag) |=> !overflow_flag;
   endproperty
   a_noflag: assert property (p_noflag) // [RQ16]
      else $error("baud rollover set overflow flag");

   property p_reload;
      @(posedge clk) disable iff (!reset_n)
      overflow |=> (count_r == $past(reloadValue));
   endproperty
   a_reload: assert property (p_reload) // [RQ11]
      else $error("no reload on rollover");

   property p_toggle;
      @(posedge clk) disable iff (!reset_n)
      (overflow && clkOutMode) |=> (countPinOut != $past(countPinOut));
   endproperty
   a_toggle: assert property (p_toggle) // [RQ19]
      else $error("clock out did not toggle");

   property p_half;
      @(posedge clk) disable iff (!reset_n)
      (timer_two_run && !timer_or_counter_select && !sixClock && countEn)
      |=> (!countEn || sixClock);
   endproperty
   a_half: assert property (p_half) // [RQ13]
      else $error("twelve clock count too fast");

   property p_ext;
      @(posedge clk) disable iff (!reset_n)
      (external_trigger_enable && trgSync_r[2] && !trgSync_r[1])
      |=> external_trigger_flag;
   endproperty
   a_ext: assert property (p_ext) // [RQ17]
      else $error("trigger edge lost");

   property p_tick;
      @(posedge clk) disable iff (!reset_n)
      txBaudTick |-> $past(overflow) && $past(transmit_clock_source);
   endproperty
   a_tick: assert property (p_tick) // [RQ10]
      else $error("tick without overflow");

endmodule

`default_nettype wire

// ===== bcot_serial_model.sv
/*
 * serial port stand-in: counts ticks and measures their spacing.
 * assumes ticks are one-cycle pulses on clk.
 */
`timescale 1ns/1ns
`default_nettype none

module bcot_serial_model
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // ticks from the timer
   input  wire logic        txBaudTick,
   input  wire logic        rxBaudTick,
   // measurements
   output logic      [15:0] txGap,
   output logic      [15:0] rxGap,
   output logic      [15:0] txN,
   output logic      [15:0] rxN
);
   logic [15:0] txCnt_r;
   logic [15:0] rxCnt_r;

   // ************************************************************
   // bit time between ticks, one tick per bit
   // ************************************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         txCnt_r <= 16'h0000;
         rxCnt_r <= 16'h0000;
         txGap   <= 16'h0000;
         rxGap   <= 16'h0000;
         txN     <= 16'h0000;
         rxN     <= 16'h0000;
      end
      else
      begin
         txCnt_r <= txBaudTick ? 16'h0001 : txCnt_r + 16'h0001;
         rxCnt_r <= rxBaudTick ? 16'h0001 : rxCnt_r + 16'h0001;
         txN     <= txN + 16'(txBaudTick);
         rxN     <= rxN + 16'(rxBaudTick);
         if (txBaudTick)
            txGap <= txCnt_r;  // transmit bit time
         if (rxBaudTick)
            rxGap <= rxCnt_r;  // receive bit time
      end
   end
endmodule

`default_nettype wire

// ===== baud_and_clockout_timer_tb_top.sv
/*
 * self-checking bench for the baud and clock-out timer.
 * assumes the timer, its package and the serial model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module baud_and_clockout_timer_tb_top;
   logic        clk, reset_n, dblSpeed, fuse, run, ctrSel, coEn;
   logic        txSel, rxSel, trigEn, flagClr, rstPin, cntPin, trigPin;
   logic [15:0] reload, cnt, txGap, rxGap, txN, rxN;
   logic        coOut, coOe, txTick, rxTick, txUse, rxUse, sixClk;
   logic        rstReq, extFlag, ovfFlag, irq;
   int          errCount = 0;
   int          nChecks = 0;
   int          cyc = 0;

   bcot_timer dut (.clk(clk), .reset_n(reset_n),
      .double_speed_select(dblSpeed), .fused_double_speed(fuse),
      .timer_two_run(run), .timer_or_counter_select(ctrSel),
      .clockout_enable(coEn), .transmit_clock_source(txSel),
      .receive_clock_source(rxSel), .external_trigger_enable(trigEn),
      .extFlagClear(flagClr), .reloadValue(reload), .resetPin(rstPin),
      .countPinIn(cntPin), .trigger_input_pin(trigPin),
      .countPinOut(coOut), .countPinOe(coOe), .txBaudTick(txTick),
      .rxBaudTick(rxTick), .txUseThisTimer(txUse),
      .rxUseThisTimer(rxUse), .sixClockMode(sixClk),
      .resetRequest(rstReq), .external_trigger_flag(extFlag),
      .overflow_flag(ovfFlag), .timerIrq(irq), .countValue(cnt));

   bcot_serial_model partner (.clk(clk), .reset_n(reset_n),
      .txBaudTick(txTick), .rxBaudTick(rxTick), .txGap(txGap),
      .rxGap(rxGap), .txN(txN), .rxN(rxN));

   // clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         errCount++;
         testDone();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         errCount++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic testDone();
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // stop, reconfigure, restart; b = speed, fuse, ctr, clkout, tx, rx
   task automatic cfg(input logic [15:0] rl, input logic [5:0] b);
      run <= 1'b0;  // stopped before reload changes
      step(2);
      reload <= rl;
      {dblSpeed, fuse, ctrSel, coEn, txSel, rxSel} <= b;
      step(1);
      run <= 1'b1;
   endtask

   // cycles high and low of one clock-out period
   task automatic coMeas(output logic [15:0] hi, output logic [15:0] lo);
      hi = 16'h0000;
      lo = 16'h0000;
      for (int i = 0; i < 300 && coOut !== 1'b0; i++) step(1);
      for (int i = 0; i < 300 && coOut !== 1'b1; i++) step(1);
      for (; coOut === 1'b1 && hi < 16'd300; hi++) step(1);
      for (; coOut === 1'b0 && lo < 16'd300; lo++) step(1);
   endtask

   task automatic tReset();
      chk(16'({sixClk, coOe, ovfFlag, irq, extFlag, txUse}), 16'h0000);
      $display("reset state done");
   endtask

   task automatic tSpeed();
      for (int i = 0; i < 4; i++)
      begin
         dblSpeed <= i[0];
         fuse     <= i[1];
         step(3);
         chk(16'(sixClk), 16'(i[0] | i[1]));
      end
      $display("speed select done");
   endtask

   // table of reloads and speeds; clock-out and both ticks together
   task automatic tRates();
      logic [15:0] rl [4] = '{16'hfffe, 16'hfffe, 16'hfff0, 16'hffff};
      logic [1:0]  sp [4] = '{2'b10, 2'b00, 2'b01, 2'b10};
      logic [15:0] hi, lo, ovf;
      // count leaves reset at zero: run it up to its first rollover
      cfg(16'hfffe, 6'b100010);
      step(65540);
      for (int i = 0; i < 4; i++)
      begin
         // cycles per overflow: span of 65536 minus reload, times 1 or 2
         ovf = (16'h0000 - rl[i]) * ((sp[i] != 2'b00) ? 16'h1 : 16'h2);
         cfg(rl[i], {sp[i], 4'b0111});
         step(600);
         coMeas(hi, lo);
         chk(hi, ovf);
         chk(lo, ovf);
         chk(txGap, 16'h10 * ovf);
         chk(rxGap, 16'h10 * ovf);
         chk(16'({coOe, ovfFlag, irq, txUse, rxUse}), 16'h0013);
      end
      // clock-out alone: rollovers still raise no flag
      cfg(16'hfffe, 6'b100100);
      step(20);
      chk(16'({coOe, ovfFlag, irq}), 16'h0004);
      run <= 1'b0;
      step(4);
      chk(16'({coOut, coOe}), 16'h0000);
      $display("rates done");
   endtask

   task automatic tRoute();
      logic [15:0] tx0, rx0;
      for (int i = 0; i < 3; i++)
      begin
         cfg(16'hfffe, {4'b1000, i[1:0]});
         step(8);
         tx0 = txN;
         rx0 = rxN;
         step(100);
         chk(16'({txUse, rxUse}), 16'(i[1:0]));
         chk(16'({txN != tx0, rxN != rx0}), 16'(i[1:0]));
         chk(16'(coOe), 16'h0000);
      end
      chk(16'(ovfFlag), 16'h0001);   // plain timer sets the flag
      // second reset in mid-run clears the sticky flags
      reset_n <= 1'b0;
      step(2);
      reset_n <= 1'b1;
      step(2);
      chk(16'({ovfFlag, irq, extFlag}), 16'h0000);
      $display("routing done");
   endtask

   task automatic tCount();
      cfg(16'hfffe, 6'b101110);
      repeat (400)
      begin
         cntPin <= ~cntPin;
         step(2);
      end
      chk(txGap, 16'h0080);     // one fall per 4 cycles, 2 per overflow
      chk(16'(coOe), 16'h0000);
      $display("pin counting done");
   endtask

   task automatic tTrig();
      logic bad;
      bad = 1'b0;
      cfg(16'hfffe, 6'b100010);
      step(100);
      trigPin <= 1'b1;
      step(4);
      trigPin <= 1'b0;
      step(6);
      chk(16'(extFlag), 16'h0000);
      trigEn  <= 1'b1;
      trigPin <= 1'b1;
      step(4);
      trigPin <= 1'b0;
      for (int i = 0; i < 100; i++)
      begin
         step(1);
         bad |= (txGap !== 16'h0020);
      end
      chk(16'({extFlag, irq, ovfFlag}), 16'h0006);
      chk(16'(bad), 16'h0000);
      flagClr <= 1'b1;
      step(1);
      flagClr <= 1'b0;
      step(3);
      chk(16'({extFlag, irq}), 16'h0000);
      $display("trigger done");
   endtask

   task automatic tRst();
      int   n [4] = '{11, 12, 23, 24};
      logic seen;
      for (int i = 0; i < 4; i++)
      begin
         dblSpeed <= (i < 2);
         fuse     <= 1'b0;
         step(4);
         rstPin <= 1'b1;
         seen = 1'b0;
         repeat (n[i])
         begin
            step(1);
            seen |= (rstReq === 1'b1);
         end
         rstPin <= 1'b0;
         repeat (8)
         begin
            step(1);
            seen |= (rstReq === 1'b1);
         end
         chk(16'(seen), 16'(i[0]));
      end
      $display("reset filter done");
   endtask

   // main sequence
   initial
   begin
      {reset_n, dblSpeed, fuse, run, ctrSel, coEn, txSel} = 7'h00;
      {rxSel, trigEn, flagClr, rstPin, cntPin, trigPin} = 6'h01;
      reload = 16'hfffe;
      step(5);
      reset_n <= 1'b1;
      step(1);
      tReset();
      tSpeed();
      tRates();
      tTrig();
      tCount();
      tRoute();
      tRst();
      testDone();
   end
endmodule

`default_nettype wire
